// ---- rtl/dpc_params.svh ----
/*
 * Constants for the position-correction block of the angle-tracking PLL.
 * Assumes one clock domain; included by the package and the modules.
 */
// Notes on behaviour
// - On a normal-to-emergency switch the state stamp becomes measured state position plus or minus (increment count minus nominal state count) at the next state slope.
// - On an emergency-to-normal switch the trigger stamp becomes measured trigger position plus or minus (increment count minus nominal trigger count) at the next trigger slope.
// - The mode used for correction is a shadow copy of the emergency select bit, taken over at the qualifying slope.
// - Both stamps may be overwritten directly by the processor and by the first helper sequencer channel.
// - After a restart into a new mode the stamp equals the measured position: state stamp for 0-to-1, trigger stamp for 1-to-0.
// - In emergency mode a detected direction change clears the lock indication.
// - After such a clear the lock indication sets again after a configurable number of missing-state gaps, two by default.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH
`define DPC_POS_W        24
`define DPC_CNT_W        16
`define DPC_GAPS_DEFAULT 2
`define DPC_GAP_W        3
`endif

// ---- rtl/dpc_pkg.sv ----
/*
 * Types shared by the correction block.
 * Assumes the params header is on the include path.
 */
`include "dpc_params.svh"
package dpc_pkg;
  typedef enum logic [1:0] {DPC_IDLE, DPC_WAIT_STATE, DPC_WAIT_TRIG} dpc_pend_t;
  typedef logic [`DPC_POS_W-1:0] dpc_pos_t;
endpackage : dpc_pkg

// ---- rtl/dpc_lock_ctrl.sv ----
/*
 * Lock indication handling after a direction change.
 * Assumes gap and direction events are one-cycle pulses on sys_clk.
 */
`timescale 1ns/100ps
`include "dpc_params.svh"
module dpc_lock_ctrl
  import dpc_pkg::*;
#(
  parameter int GAP_W = `DPC_GAP_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             pllGlobalEnable,
  input  wire logic             emergencyActive,
  input  wire logic             dirChange,
  input  wire logic             missingStateGap,
  input  wire logic [GAP_W-1:0] gapsToRelock,
  output logic                  lockIndication
);
  logic [GAP_W-1:0] gapCnt_reg;
  logic             relock_reg;

  // ********************
  // Relock counting
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_reg <= '0;
      relock_reg <= 1'b0;
    end else if (!pllGlobalEnable) begin
      gapCnt_reg <= '0;
      relock_reg <= 1'b0;
    end else if (emergencyActive && dirChange) begin
      gapCnt_reg <= '0;
      relock_reg <= 1'b1;
    end else if (relock_reg && missingStateGap) begin
      if (gapCnt_reg + GAP_W'(1) >= gapsToRelock) begin
        gapCnt_reg <= '0;
        relock_reg <= 1'b0;
      end else begin
        gapCnt_reg <= gapCnt_reg + GAP_W'(1);
      end
    end
  end

  // Lock dropped on disable in any mode, and by a turn only in emergency mode; otherwise held set while enabled and no relock is counting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockIndication <= 1'b0;
    end else if (!pllGlobalEnable) begin
      lockIndication <= 1'b0;
    end else if (emergencyActive && dirChange) begin
      lockIndication <= 1'b0;
    end else if (relock_reg && missingStateGap && (gapCnt_reg + GAP_W'(1) >= gapsToRelock)) begin
      lockIndication <= 1'b1;
    end else if (!relock_reg) begin
      lockIndication <= 1'b1;
    end
  end
endmodule : dpc_lock_ctrl

// ---- rtl/dpc_position_correction.sv ----
/*
 * Position stamp correction on mode switches, restart and overwrite.
 * Assumes slopes, gaps and direction events are one-cycle pulses and that
 * software follows the restart order and corrects stamps when no slope comes.
 */
`timescale 1ns/100ps
`include "dpc_params.svh"
module dpc_position_correction
  import dpc_pkg::*;
#(
  parameter int POS_W = `DPC_POS_W,
  parameter int CNT_W = `DPC_CNT_W,
  parameter int GAP_W = `DPC_GAP_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             pllGlobalEnable,
  input  wire logic             emergencyModeSelect,
  input  wire logic             stateInputEnable,
  input  wire logic             triggerInputEnable,
  input  wire logic             stateSlope,
  input  wire logic             triggerSlope,
  input  wire logic             directionBackward,
  input  wire logic             dirChange,
  input  wire logic             missingStateGap,
  input  wire logic [GAP_W-1:0] gapsToRelock,
  input  wire logic [POS_W-1:0] measuredStatePosition,
  input  wire logic [POS_W-1:0] measuredTriggerPosition,
  input  wire logic [CNT_W-1:0] incrementCounter,
  input  wire logic [CNT_W-1:0] nominalStateCount,
  input  wire logic [CNT_W-1:0] nominalTriggerCount,
  input  wire logic             cpuStateStampWr,
  input  wire logic             cpuTriggerStampWr,
  input  wire logic [POS_W-1:0] cpuStampData,
  input  wire logic             seqStateStampWr,
  input  wire logic             seqTriggerStampWr,
  input  wire logic [POS_W-1:0] seqStampData,
  output logic [POS_W-1:0]      statePositionStamp,
  output logic [POS_W-1:0]      triggerPositionStamp,
  output logic                  modeShadow,
  output logic                  correctionPending,
  output logic                  lockIndication
);
  dpc_pend_t        pend_reg;
  logic             enPrev_reg;
  logic             restart_reg;
  logic [CNT_W-1:0] incCnt_reg;
  logic [CNT_W-1:0] nomState_reg;
  logic [CNT_W-1:0] nomTrig_reg;
  logic             stQual;
  logic             trQual;
  logic             modeEdge;
  logic [POS_W-1:0] corrState;
  logic [POS_W-1:0] corrTrig;

  function automatic logic [POS_W-1:0] applyCorr(input logic [POS_W-1:0] pos,
      input logic [CNT_W-1:0] inc, input logic [CNT_W-1:0] nom, input logic back);
    logic [POS_W-1:0] delta;
    delta = POS_W'(inc - nom);
    return back ? pos - delta : pos + delta;
  endfunction : applyCorr

  assign stQual = pllGlobalEnable && stateInputEnable && stateSlope;
  assign trQual = pllGlobalEnable && triggerInputEnable && triggerSlope;
  assign modeEdge = (stQual || trQual) && (emergencyModeSelect != modeShadow);
  // Registered counts are used, so a correction sees the previous slope's counts
  assign corrState = applyCorr(measuredStatePosition, incCnt_reg, nomState_reg,
                               directionBackward);
  assign corrTrig  = applyCorr(measuredTriggerPosition, incCnt_reg, nomTrig_reg,
                               directionBackward);

  // ********************
  // Mode shadow and restart
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeShadow  <= 1'b0;
      enPrev_reg  <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      enPrev_reg <= pllGlobalEnable;
      if (pllGlobalEnable && !enPrev_reg && (emergencyModeSelect != modeShadow)) begin
        restart_reg <= 1'b1;
      end else if (!pllGlobalEnable) begin
        restart_reg <= 1'b0;
      end else if (stQual || trQual) begin
        restart_reg <= 1'b0;
      end
      if (stQual || trQual) begin
        modeShadow <= emergencyModeSelect;
      end
    end
  end

  // ********************
  // Sampled counts
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      incCnt_reg   <= '0;
      nomState_reg <= '0;
      nomTrig_reg  <= '0;
    end else if (stQual || trQual) begin
      incCnt_reg   <= incrementCounter;
      nomState_reg <= nominalStateCount;
      nomTrig_reg  <= nominalTriggerCount;
    end
  end

  // ********************
  // Pending correction
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= DPC_IDLE;
    end else if (!pllGlobalEnable) begin
      pend_reg <= DPC_IDLE;
    end else begin
      unique case (pend_reg)
        DPC_IDLE: begin
          if (modeEdge && !trQual && !stQual) begin
            pend_reg <= DPC_IDLE;
          end else if (modeEdge && emergencyModeSelect && !stQual) begin
            pend_reg <= DPC_WAIT_STATE;
          end else if (modeEdge && !emergencyModeSelect && !trQual) begin
            pend_reg <= DPC_WAIT_TRIG;
          end
        end
        DPC_WAIT_STATE: begin
          if (stQual || cpuStateStampWr || seqStateStampWr) begin
            pend_reg <= DPC_IDLE;
          end
        end
        DPC_WAIT_TRIG: begin
          if (trQual || cpuTriggerStampWr || seqTriggerStampWr) begin
            pend_reg <= DPC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      correctionPending <= 1'b0;
    end else begin
      correctionPending <= (pend_reg != DPC_IDLE);
    end
  end

  // ********************
  // Stamps
  // ********************
  // Overwrite wins over slope correction; CPU wins over sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      statePositionStamp <= '0;
    end else if (cpuStateStampWr) begin
      statePositionStamp <= cpuStampData;
    end else if (seqStateStampWr) begin
      statePositionStamp <= seqStampData;
    end else if (stQual && emergencyModeSelect && !modeShadow && restart_reg) begin
      statePositionStamp <= measuredStatePosition;
    end else if (stQual && ((emergencyModeSelect && !modeShadow) ||
                            pend_reg == DPC_WAIT_STATE)) begin
      statePositionStamp <= corrState;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      triggerPositionStamp <= '0;
    end else if (cpuTriggerStampWr) begin
      triggerPositionStamp <= cpuStampData;
    end else if (seqTriggerStampWr) begin
      triggerPositionStamp <= seqStampData;
    end else if (trQual && !emergencyModeSelect && modeShadow && restart_reg) begin
      triggerPositionStamp <= measuredTriggerPosition;
    end else if (trQual && ((!emergencyModeSelect && modeShadow) ||
                            pend_reg == DPC_WAIT_TRIG)) begin
      triggerPositionStamp <= corrTrig;
    end
  end

  // ********************
  // Lock indication
  // ********************
  dpc_lock_ctrl #(.GAP_W(GAP_W)) uLock (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .pllGlobalEnable (pllGlobalEnable),
    .emergencyActive (modeShadow),
    .dirChange       (dirChange),
    .missingStateGap (missingStateGap),
    .gapsToRelock    (gapsToRelock),
    .lockIndication  (lockIndication)
  );
endmodule : dpc_position_correction

// ---- testbench/dpc_pc_asserts.sv ----
/* Concurrent checks on the position correction block.
   Bound to its top module; sees only its ports. */
`timescale 1ns/100ps
module dpc_pc_asserts
  import dpc_pkg::*;
#(
  parameter int POS_W = 24
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             pllGlobalEnable,
  input wire logic             emergencyModeSelect,
  input wire logic             stateInputEnable,
  input wire logic             stateSlope,
  input wire logic             triggerSlope,
  input wire logic             dirChange,
  input wire logic             missingStateGap,
  input wire logic             cpuStateStampWr,
  input wire logic             cpuTriggerStampWr,
  input wire logic [POS_W-1:0] cpuStampData,
  input wire logic             seqStateStampWr,
  input wire logic [POS_W-1:0] seqStampData,
  input wire logic [POS_W-1:0] statePositionStamp,
  input wire logic [POS_W-1:0] triggerPositionStamp,
  input wire logic             modeShadow,
  input wire logic             lockIndication
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ******
  // Checks
  // ******
  lock_drop_a: assert property (dirChange && modeShadow && pllGlobalEnable
    && !missingStateGap |=> !lockIndication) else $error("lock kept after turn");
  lock_rise_a: assert property ($rose(lockIndication) |-> $past(pllGlobalEnable))
    else $error("lock set while disabled");
  cpu_state_a: assert property (cpuStateStampWr |=>
    statePositionStamp == $past(cpuStampData)) else $error("state stamp missed write");
  cpu_trig_a: assert property (cpuTriggerStampWr |=>
    triggerPositionStamp == $past(cpuStampData)) else $error("trigger stamp missed write");
  seq_state_a: assert property (seqStateStampWr && !cpuStateStampWr |=>
    statePositionStamp == $past(seqStampData)) else $error("sequencer write lost");
  // Stamp may only move on a slope or a write
  state_hold_a: assert property (!stateSlope && !cpuStateStampWr && !seqStateStampWr
    |=> $stable(statePositionStamp)) else $error("state stamp moved alone");
  shadow_hold_a: assert property (pllGlobalEnable && !stateSlope && !triggerSlope
    |=> $stable(modeShadow)) else $error("shadow moved without slope");
  shadow_take_a: assert property (stateSlope && stateInputEnable && pllGlobalEnable
    && emergencyModeSelect |=> modeShadow) else $error("shadow not taken at slope");
endmodule : dpc_pc_asserts

bind dpc_position_correction dpc_pc_asserts #(.POS_W(POS_W)) u_chk (.*);

// ---- testbench/dpc_slope_src.sv ----
/* Slope source model: state and trigger slopes with measured positions.
   Driven by tasks from the bench, one cycle pulses after the edge. */
`timescale 1ns/100ps
module dpc_slope_src
  import dpc_pkg::*;
(
  input wire logic sys_clk,
  output logic     stateSlope,
  output logic     triggerSlope,
  output dpc_pos_t measuredStatePosition,
  output dpc_pos_t measuredTriggerPosition
);
  // ******
  // Slopes
  // ******
  initial begin
    stateSlope = 1'h0;
    triggerSlope = 1'h0;
    measuredStatePosition = 24'h0;
    measuredTriggerPosition = 24'h0;
  end
  task automatic fire(input logic st, input dpc_pos_t pos);
    @(posedge sys_clk);
    #1;
    if (st) begin
      measuredStatePosition = pos;
      stateSlope = 1'h1;
    end else begin
      measuredTriggerPosition = pos;
      triggerSlope = 1'h1;
    end
    @(posedge sys_clk);
    #1;
    stateSlope = 1'h0;
    triggerSlope = 1'h0;
    // Stale position must not be reused later
    measuredStatePosition = ~measuredStatePosition;
    measuredTriggerPosition = ~measuredTriggerPosition;
  endtask : fire
endmodule : dpc_slope_src

// ---- testbench/dpc_position_correction_tb.sv ----
/* Bench for the correction block: mode switches, overwrite, restart, lock.
   Assumes the slope source model and the checker are compiled first. */
`timescale 1ns/100ps
module dpll_position_correction_tb;
  import dpc_pkg::*;
  typedef struct {logic sel; logic bk; dpc_pos_t pos; logic [15:0] inc; dpc_pos_t exp;} dpc_row_t;
  logic        sys_clk = 1'h0, rst_n = 1'h0, pllGlobalEnable = 1'h0, emergencyModeSelect = 1'h0;
  logic        stateInputEnable = 1'h1, triggerInputEnable = 1'h1, directionBackward = 1'h0;
  logic        dirChange = 1'h0, missingStateGap = 1'h0, cpuStateStampWr = 1'h0;
  logic        cpuTriggerStampWr = 1'h0, seqStateStampWr = 1'h0, seqTriggerStampWr = 1'h0;
  logic        stateSlope, triggerSlope, modeShadow, correctionPending, lockIndication;
  logic [2:0]  gapsToRelock = 3'h2;
  logic [15:0] incrementCounter = 16'h0, nominalStateCount = 16'h10, nominalTriggerCount = 16'h20;
  dpc_pos_t    cpuStampData = 24'ha5a5a5, seqStampData = 24'h5a5a5a, measuredStatePosition;
  dpc_pos_t    measuredTriggerPosition, statePositionStamp, triggerPositionStamp;
  int          error_cnt = 0, check_count = 0;
  // Expected stamp: pos +/- (inc - nominal), wrapping at 24 bits
  dpc_row_t    rows [4] = '{'{1'h1, 1'h0, 24'h100000, 16'h50, 24'h100040},
                            '{1'h0, 1'h0, 24'h200000, 16'h50, 24'h200030},
                            '{1'h1, 1'h1, 24'h000010, 16'h90, 24'hffff90},
                            '{1'h0, 1'h1, 24'h300000, 16'h21, 24'h2fffff}};
  dpc_position_correction u_dut (.*);
  dpc_slope_src           u_src (.*);
  // *****
  // Tasks
  // *****
  task automatic cmp(input string nm, input dpc_pos_t exp, input dpc_pos_t got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic cmpb(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : cmpb
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask : pulse
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // *****
  // Tests
  // *****
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    // Whole run is about 70 cycles; this leaves ample margin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    tick(8);
    rst_n = 1'h1;
    cmp("resetStamp", 24'h0, statePositionStamp);
    cmpb("resetShadow", 1'h0, modeShadow);
    pllGlobalEnable = 1'h1;
    foreach (rows[i]) begin
      directionBackward = rows[i].bk;
      incrementCounter = rows[i].inc;
      emergencyModeSelect = rows[i].sel;
      // Switch taken at the other slope, so the matching correction is pending
      u_src.fire(!rows[i].sel, 24'h0);
      incrementCounter = 16'hffff;
      tick(2);
      cmpb("pending", 1'h1, correctionPending);
      u_src.fire(rows[i].sel, rows[i].pos);
      if (rows[i].sel)
        cmp("stateStamp", rows[i].exp, statePositionStamp);
      else
        cmp("trigStamp", rows[i].exp, triggerPositionStamp);
      cmpb("shadow", rows[i].sel, modeShadow);
    end
    $display("test switches done");
    stateInputEnable = 1'h0;
    emergencyModeSelect = 1'h1;
    u_src.fire(1'h1, 24'h123456);
    cmp("gatedStamp", 24'hffff90, statePositionStamp);
    cmpb("gatedShadow", 1'h0, modeShadow);
    stateInputEnable = 1'h1;
    $display("test gated slope done");
    cpuStateStampWr = 1'h1;
    seqStateStampWr = 1'h1;
    seqTriggerStampWr = 1'h1;
    tick(1);
    cmp("cpuWins", 24'ha5a5a5, statePositionStamp);
    cpuStateStampWr = 1'h0;
    seqTriggerStampWr = 1'h0;
    cpuTriggerStampWr = 1'h1;
    tick(1);
    cpuTriggerStampWr = 1'h0;
    seqStateStampWr = 1'h0;
    cmp("seqState", 24'h5a5a5a, statePositionStamp);
    cmp("cpuTrig", 24'ha5a5a5, triggerPositionStamp);
    tick(1);
    cmpb("pendCleared", 1'h0, correctionPending);
    $display("test overwrite done");
    for (int k = 1; k >= 0; k--) begin
      pllGlobalEnable = 1'h0;
      tick(1);
      emergencyModeSelect = k[0];
      pllGlobalEnable = 1'h1;
      u_src.fire(k[0], 24'h0abcde);
      cmp("restart", 24'h0abcde, k ? statePositionStamp : triggerPositionStamp);
    end
    $display("test restart done");
    emergencyModeSelect = 1'h1;
    u_src.fire(1'h1, 24'h0);
    for (int g = 2; g <= 4; g += 2) begin
      gapsToRelock = g[2:0];
      tick(1);
      cmpb("lockHeld", 1'h1, lockIndication);
      pulse(dirChange);
      cmpb("lockDrop", 1'h0, lockIndication);
      repeat (g - 1) pulse(missingStateGap);
      cmpb("lockWait", 1'h0, lockIndication);
      pulse(missingStateGap);
      tick(1);
      cmpb("relock", 1'h1, lockIndication);
    end
    emergencyModeSelect = 1'h0;
    u_src.fire(1'h0, 24'h0);
    pulse(dirChange);
    cmpb("normalTurn", 1'h1, lockIndication);
    $display("test lock done");
    final_report();
  end
endmodule : dpll_position_correction_tb
